/* hw/rbw_defines.svh */
//----------------------------------------------------------------------
// Purpose: offsets, field positions, reset values and link timing
// Assumes: byte-wide command registers, 8-bit command offsets
// Notes  : shared by both ends of the serial command channel
//----------------------------------------------------------------------
`ifndef RBW_DEFINES_SVH
`define RBW_DEFINES_SVH

// ---------------------------------------------------------------------
// command channel offsets
// ---------------------------------------------------------------------
`define RBW_OFS_SEL_ENABLE   8'h0A
`define RBW_OFS_SEL_MAIN     8'h0B
`define RBW_OFS_SEL_WD       8'h0C
`define RBW_OFS_WINDOW       8'h15
`define RBW_OFS_ANSWER       8'h16
`define RBW_OFS_ANSWER_SYNC  8'h17
`define RBW_OFS_HB_PERIOD    8'h18

// ---------------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------------
`define RBW_CLOSED_MSB       7
`define RBW_CLOSED_LSB       2
`define RBW_OPEN_MSB         1
`define RBW_OPEN_LSB         0
`define RBW_HB_MSB           6
`define RBW_SEL_ENABLE_MASK  8'h1F
`define RBW_SEL_MAIN_MASK    8'h7F
`define RBW_SEL_WD_MASK      8'h0F
`define RBW_CMD_RESET        8'h00

// ---------------------------------------------------------------------
// watchdog time steps (microseconds, as printed)
// ---------------------------------------------------------------------
`define RBW_CLOSED_STEP_US   1600
`define RBW_OPEN_STEP_US     3200
`define RBW_HB_STEP_US       1600

// ---------------------------------------------------------------------
// link framing and host bus map
// ---------------------------------------------------------------------
`define RBW_FRAME_BITS       16
`define RBW_LINK_HALF_DIV    2
`define RBW_APB_CMD          12'h000
`define RBW_APB_STATUS       12'h004
`define RBW_STATUS_BUSY_BIT  0

`endif

/* hw/rbw_pkg.sv */
//----------------------------------------------------------------------
// Purpose: shared types of the readback select and watchdog commands
// Assumes: rbw_defines.svh carries every number
// Notes  : types only
//----------------------------------------------------------------------
package rbw_pkg;

    // host link sequencer states
    typedef enum logic [1:0] {
        RBW_IDLE,
        RBW_SHIFT,
        RBW_GAP
    } rbw_hstate_e;

    // one command frame: offset then data
    typedef struct packed {
        logic [7:0] ofs;
        logic [7:0] data;
    } rbw_frame_s;

    // flat index of a readback request: group * 8 + bit
    typedef logic [4:0] rbw_req_t;

endpackage : rbw_pkg

/* hw/rbw_link_if.sv */
//----------------------------------------------------------------------
// Purpose: serial command channel between host and device
// Assumes: host makes the link clock
// Notes  : data changes on falling link edge, sampled on rising edge
//----------------------------------------------------------------------
`timescale 1ns/1ps

interface rbw_link_if;
    logic lnk_clk;   // link clock, free running, from host
    logic lnk_cs_n;  // frame select, active low
    logic lnk_mosi;  // command data, msb first

    modport host (
        output lnk_clk,
        output lnk_cs_n,
        output lnk_mosi
    );

    modport dev (
        input  lnk_clk,
        input  lnk_cs_n,
        input  lnk_mosi
    );
endinterface : rbw_link_if

/* hw/rbw_dev.sv */
//----------------------------------------------------------------------
// Purpose: device end: command decode, readback bursts, watchdog set
// Assumes: link clock runs free; frames are 16 bits, offset first
// Notes  : whole module runs on the link clock
//----------------------------------------------------------------------
// How it works
// - enable select: bit4 sensor cfg2, bits3-0 enables
// - burst returns requests from msb down
// - main select bits6-0: seven config/status registers
// - watchdog select: two status, two heartbeat
// - closed window code n gives n*1.6ms
// - closed code zero keeps both window settings
// - open window code gives 3.2ms steps
// - answer byte write, heartbeat untouched
// - answer sync write resynchronises heartbeat
// - period code loads period, resyncs, zero keeps
// - all command fields reset to zero
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "rbw_defines.svh"

module rbw_dev
    import rbw_pkg::*;
#(
    parameter int FRAME_BITS = `RBW_FRAME_BITS
) (
    // link side
    rbw_link_if.dev         lnk,
    input  wire logic       sys_rst,
    // readback request stream
    output logic            rb_valid,
    output rbw_req_t        rb_req,
    // window watchdog settings
    output logic [5:0]      closed_window_time,
    output logic [1:0]      open_window_time,
    // functional watchdog answer
    output logic            answer_valid,
    output logic [7:0]      answer_byte,
    // heartbeat
    output logic [6:0]      heartbeat_period,
    output logic            heartbeat_sync
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (FRAME_BITS != 16) begin : g_bad_frame
        $error("rbw_dev: FRAME_BITS must be 16");
    end

    // ------------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------------
    // reset comes from the system side; two flops before any use
    logic rst_meta;
    logic rst_sync;

    always_ff @(posedge lnk.lnk_clk) begin
        rst_meta <= sys_rst;
        rst_sync <= rst_meta;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // highest set bit of the pending vector, used for burst ordering
    function automatic rbw_req_t top_bit(input logic [23:0] v);
        rbw_req_t r;
        r = 5'h00;
        for (int i = 0; i < 24; i++) begin
            if (v[i]) begin
                r = rbw_req_t'(i);
            end
        end
        return r;
    endfunction : top_bit

    // ------------------------------------------------------------------
    // frame receiver
    // ------------------------------------------------------------------
    logic [14:0]   rx_shift;
    logic [3:0]    rx_cnt;
    logic          rx_done;
    rbw_frame_s    rx_word;

    // shift while selected; a short frame is dropped when select rises
    always_ff @(posedge lnk.lnk_clk) begin
        if (rst_sync || lnk.lnk_cs_n) begin
            rx_cnt   <= 4'h0;
            rx_shift <= 15'h0000;
        end else begin
            rx_shift <= {rx_shift[13:0], lnk.lnk_mosi};
            rx_cnt   <= rx_cnt + 4'h1;
        end
    end

    // last bit of a frame completes the word in this cycle
    assign rx_done = !lnk.lnk_cs_n && (rx_cnt == 4'hF);
    assign rx_word = {rx_shift, lnk.lnk_mosi};

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    logic wr_sel_en;
    logic wr_sel_main;
    logic wr_sel_wd;
    logic wr_window;
    logic wr_answer;
    logic wr_answer_sync;
    logic wr_hb;

    always_comb begin
        wr_sel_en      = rx_done && rx_word.ofs == `RBW_OFS_SEL_ENABLE;
        wr_sel_main    = rx_done && rx_word.ofs == `RBW_OFS_SEL_MAIN;
        wr_sel_wd      = rx_done && rx_word.ofs == `RBW_OFS_SEL_WD;
        wr_window      = rx_done && rx_word.ofs == `RBW_OFS_WINDOW;
        wr_answer      = rx_done && rx_word.ofs == `RBW_OFS_ANSWER;
        wr_answer_sync = rx_done && rx_word.ofs == `RBW_OFS_ANSWER_SYNC;
        wr_hb          = rx_done && rx_word.ofs == `RBW_OFS_HB_PERIOD;
    end

    // ------------------------------------------------------------------
    // readback select registers
    // ------------------------------------------------------------------
    // reserved bits are masked off so they never start a burst
    logic [7:0] next_sel_en;
    logic [7:0] next_sel_main;
    logic [7:0] next_sel_wd;

    always_comb begin
        next_sel_en   = rx_word.data & `RBW_SEL_ENABLE_MASK;
        next_sel_main = rx_word.data & `RBW_SEL_MAIN_MASK;
        next_sel_wd   = rx_word.data & `RBW_SEL_WD_MASK;
    end

    // pending requests: group 0 bits 4:0, group 1 bits 14:8, group 2 19:16
    logic [23:0] pend;
    logic [23:0] pend_set;
    logic [23:0] pend_clr;
    rbw_req_t    pend_top;

    always_comb begin
        pend_set = 24'h000000;
        if (wr_sel_en) begin
            pend_set[7:0] = next_sel_en;
        end
        if (wr_sel_main) begin
            pend_set[15:8] = next_sel_main;
        end
        if (wr_sel_wd) begin
            pend_set[23:16] = next_sel_wd;
        end
    end

    assign pend_top = top_bit(pend);

    // one request leaves per cycle; a zero write adds nothing
    always_comb begin
        pend_clr = 24'h000000;
        if (pend != 24'h000000) begin
            pend_clr[pend_top] = 1'b1;
        end
    end

    // a fresh request in the cycle its bit leaves is kept: set wins
    always_ff @(posedge lnk.lnk_clk) begin
        if (rst_sync) begin
            pend <= 24'h000000;
        end else begin
            pend <= (pend & ~pend_clr) | pend_set;
        end
    end

    // request stream, one cycle per selected register
    always_ff @(posedge lnk.lnk_clk) begin
        if (rst_sync) begin
            rb_valid <= 1'b0;
            rb_req   <= 5'h00;
        end else begin
            rb_valid <= pend != 24'h000000;
            rb_req   <= pend_top;
        end
    end

    // ------------------------------------------------------------------
    // window watchdog times
    // ------------------------------------------------------------------
    // open and closed are taken together or not at all
    always_ff @(posedge lnk.lnk_clk) begin
        if (rst_sync) begin
            closed_window_time <= 6'h00;
            open_window_time   <= 2'h0;
        end else if (wr_window &&
                     rx_word.data[`RBW_CLOSED_MSB:`RBW_CLOSED_LSB]
                     != 6'h00) begin
            closed_window_time <=
                rx_word.data[`RBW_CLOSED_MSB:`RBW_CLOSED_LSB];
            open_window_time   <=
                rx_word.data[`RBW_OPEN_MSB:`RBW_OPEN_LSB];
        end
    end

    // ------------------------------------------------------------------
    // functional watchdog answer
    // ------------------------------------------------------------------
    always_ff @(posedge lnk.lnk_clk) begin
        if (rst_sync) begin
            answer_valid <= 1'b0;
            answer_byte  <= `RBW_CMD_RESET;
        end else begin
            answer_valid <= wr_answer || wr_answer_sync;
            if (wr_answer || wr_answer_sync) begin
                answer_byte <= rx_word.data;
            end
        end
    end

    // ------------------------------------------------------------------
    // heartbeat period and resync
    // ------------------------------------------------------------------
    // plain answer leaves heartbeat timing alone
    always_ff @(posedge lnk.lnk_clk) begin
        if (rst_sync) begin
            heartbeat_sync <= 1'b0;
        end else begin
            heartbeat_sync <= wr_answer_sync || wr_hb;
        end
    end

    // zero code keeps the old period but still resyncs
    always_ff @(posedge lnk.lnk_clk) begin
        if (rst_sync) begin
            heartbeat_period <= 7'h00;
        end else if (wr_hb && rx_word.data[`RBW_HB_MSB:0] != 7'h00) begin
            heartbeat_period <= rx_word.data[`RBW_HB_MSB:0];
        end
    end

endmodule : rbw_dev

/* hw/rbw_host.sv */
//----------------------------------------------------------------------
// Purpose: host end: APB command port driving the serial channel
// Assumes: clk_sys 200 MHz; link clock made here by a divider
// Notes  : one frame in flight; a second command write waits
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "rbw_defines.svh"

module rbw_host
    import rbw_pkg::*;
#(
    parameter int HALF_DIV = `RBW_LINK_HALF_DIV
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // link side
    rbw_link_if.host         lnk
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (HALF_DIV < 1 || HALF_DIV > 255) begin : g_bad_div
        $error("rbw_host: HALF_DIV must be 1 to 255");
    end

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    rbw_frame_s   cmd_word;
    logic         pend;
    logic         busy;
    logic         hit_cmd;
    logic         hit_stat;
    logic         access;
    logic         start;
    rbw_hstate_e  state;

    assign hit_cmd  = paddr == `RBW_APB_CMD;
    assign hit_stat = paddr == `RBW_APB_STATUS;
    assign access   = psel && penable;
    assign busy     = pend || state != RBW_IDLE;
    // a command write stalls until the previous frame is gone
    assign pready   = !(pwrite && hit_cmd && busy);
    assign pslverr  = access && !hit_cmd && !hit_stat;
    assign start    = access && pready && pwrite && hit_cmd;

    // read mux; unmapped reads zero
    always_comb begin
        prdata = 32'h00000000;
        if (hit_cmd) begin
            prdata[15:0] = cmd_word;
        end else if (hit_stat) begin
            prdata[`RBW_STATUS_BUSY_BIT] = busy;
        end
    end

    // ------------------------------------------------------------------
    // link clock divider, free running
    // ------------------------------------------------------------------
    logic [7:0] div_cnt;
    logic       fall;

    assign fall = (div_cnt == 8'(HALF_DIV - 1)) && lnk.lnk_clk;

    always_ff @(posedge clk_sys) begin
        if (sys_rst || div_cnt == 8'(HALF_DIV - 1)) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lnk.lnk_clk <= 1'b0;
        end else if (div_cnt == 8'(HALF_DIV - 1)) begin
            lnk.lnk_clk <= !lnk.lnk_clk;
        end
    end

    // ------------------------------------------------------------------
    // command latch
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmd_word <= 16'h0000;
            pend     <= 1'b0;
        end else begin
            if (start) begin
                cmd_word <= pwdata[15:0];
            end
            // start cannot meet the pickup: writes stall while busy
            pend <= start || (pend && !(fall && state == RBW_IDLE));
        end
    end

    // ------------------------------------------------------------------
    // frame sequencer; bits change on the falling link edge
    // ------------------------------------------------------------------
    logic [15:0] tx;
    logic [4:0]  nbits;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state        <= RBW_IDLE;
            tx           <= 16'h0000;
            nbits        <= 5'h00;
            lnk.lnk_cs_n <= 1'b1;
            lnk.lnk_mosi <= 1'b0;
        end else if (fall) begin
            unique case (state)
                RBW_IDLE: begin
                    if (pend) begin
                        lnk.lnk_cs_n <= 1'b0;
                        lnk.lnk_mosi <= cmd_word[15];
                        tx           <= {cmd_word[14:0], 1'b0};
                        nbits        <= 5'h01;
                        state        <= RBW_SHIFT;
                    end
                end
                RBW_SHIFT: begin
                    if (nbits == 5'(`RBW_FRAME_BITS)) begin
                        lnk.lnk_cs_n <= 1'b1;
                        state        <= RBW_GAP;
                    end else begin
                        lnk.lnk_mosi <= tx[15];
                        tx           <= {tx[14:0], 1'b0};
                        nbits        <= nbits + 5'h01;
                    end
                end
                RBW_GAP: begin
                    state <= RBW_IDLE;  // one idle link period
                end
                default: begin
                    state <= RBW_IDLE;  // unused code recovers
                end
            endcase
        end
    end

endmodule : rbw_host

/* verification/rbw_assertions.sv */
//----------------------------------------------------------------------
// Purpose: link-side checks between host and device ends
// Assumes: one lnk_clk domain, device reset active high
// Notes  : watches the interface and the device outputs only
//----------------------------------------------------------------------
`timescale 1ns/1ps

module rbw_assertions
    import rbw_pkg::*;
(
    // link
    input wire logic       lnk_clk,
    input wire logic       lnk_cs_n,
    input wire logic       lnk_mosi,
    input wire logic       sys_rst,
    // device outputs
    input wire logic       rb_valid,
    input wire rbw_req_t   rb_req,
    input wire logic [5:0] closed_window_time,
    input wire logic [1:0] open_window_time,
    input wire logic       answer_valid,
    input wire logic [7:0] answer_byte,
    input wire logic [6:0] heartbeat_period,
    input wire logic       heartbeat_sync
);
    // ------------------------------------------------------------------
    // all checks on the link clock
    // ------------------------------------------------------------------
    default clocking cb @(posedge lnk_clk); endclocking
    default disable iff (sys_rst);

    a_req_in_map: assert property (rb_valid |->
        rb_req inside {[0:4], [8:14], [16:19]})
        else $error("readback index outside the select map");
    a_burst_msb_first: assert property (
        rb_valid && $past(rb_valid) |-> rb_req < $past(rb_req))
        else $error("burst not in descending order");
    a_burst_after_frame: assert property (
        $rose(rb_valid) |-> !$past(lnk_cs_n, 2))
        else $error("burst without a finished frame");
    a_answer_cause: assert property (
        $changed(answer_byte) |-> answer_valid)
        else $error("answer byte moved without a pulse");
    a_answer_pulse: assert property (
        answer_valid |=> !answer_valid)
        else $error("answer pulse longer than one cycle");
    a_sync_pulse: assert property (
        heartbeat_sync |=> !heartbeat_sync)
        else $error("sync pulse longer than one cycle");
    a_period_load: assert property ($changed(heartbeat_period) |->
        heartbeat_sync && heartbeat_period != 7'h00)
        else $error("period changed without sync or to zero");
    a_window_keep: assert property (
        $changed(closed_window_time) || $changed(open_window_time)
        |-> closed_window_time != 6'h00)
        else $error("window changed by a zero closed code");
endmodule : rbw_assertions

/* verification/readback_select_and_watchdog_cmds_test.sv */
//----------------------------------------------------------------------
// Purpose: host and device ends joined, driven over APB
// Assumes: host makes the link clock; device reset released later
// Notes  : link traffic is host to device only
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "rbw_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
    err_count++; $display("ERROR %0t got %0h exp %0h", $time, a, b); \
    end end

module readback_select_and_watchdog_cmds_test;
    import rbw_pkg::*;
    logic        clk_sys = 0;
    logic        sys_rst = 1;
    logic        dev_rst = 1;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, er, rb_valid, answer_valid;
    logic        heartbeat_sync;
    rbw_req_t    rb_req;
    rbw_req_t    got[$], exp_q[$];
    logic [5:0]  closed_window_time;
    logic [1:0]  open_window_time;
    logic [7:0]  answer_byte;
    logic [6:0]  heartbeat_period;
    int          err_count = 0, num_checks = 0, n_ans = 0, n_sync = 0;
    int          a0, s0;

    always #2.5 clk_sys = ~clk_sys;
    rbw_link_if lnk ();
    rbw_host u_rbw_host (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .lnk(lnk));
    rbw_dev u_rbw_dev (.lnk(lnk), .sys_rst(dev_rst), .rb_valid(rb_valid),
        .rb_req(rb_req), .closed_window_time(closed_window_time),
        .open_window_time(open_window_time), .answer_valid(answer_valid),
        .answer_byte(answer_byte), .heartbeat_period(heartbeat_period),
        .heartbeat_sync(heartbeat_sync));
    rbw_assertions u_rbw_assertions (.lnk_clk(lnk.lnk_clk),
        .lnk_cs_n(lnk.lnk_cs_n), .lnk_mosi(lnk.lnk_mosi),
        .sys_rst(dev_rst), .rb_valid(rb_valid), .rb_req(rb_req),
        .closed_window_time(closed_window_time),
        .open_window_time(open_window_time), .answer_valid(answer_valid),
        .answer_byte(answer_byte), .heartbeat_period(heartbeat_period),
        .heartbeat_sync(heartbeat_sync));

    // device monitor, link domain
    always @(posedge lnk.lnk_clk) begin
        if (dev_rst === 1'b0) begin
            if (rb_valid === 1'b1) got.push_back(rb_req);
            if (answer_valid === 1'b1) n_ans++;
            if (heartbeat_sync === 1'b1) n_sync++;
        end
    end

    // one apb transfer; waits for pready, only the watchdog bounds it
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb

    // command frame, then wait for idle and burst drain
    task send(input logic [7:0] o, input logic [7:0] d);
        apb(1, `RBW_APB_CMD, {16'h0000, o, d});
        do apb(0, `RBW_APB_STATUS, 0);
        while (rd[`RBW_STATUS_BUSY_BIT] !== 1'b0);
        repeat (60) @(posedge clk_sys);
    endtask : send

    // select write; expected order from msb of the masked byte down
    task sel(input int g, input logic [7:0] o, d, m);
        got.delete();
        exp_q.delete();
        for (int b = 7; b >= 0; b--)
            if (d[b] & m[b]) exp_q.push_back(rbw_req_t'(g * 8 + b));
        send(o, d);
        `CHK(got.size(), exp_q.size())
        foreach (exp_q[i]) `CHK(got[i], exp_q[i])
    endtask : sel

    task conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    // watchdog: tests need about 11 us
    initial begin
        #200000;
        err_count++;
        conclude();
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 0;
        // device reset spans running link edges, released on its own clock
        repeat (5) @(posedge lnk.lnk_clk);
        dev_rst <= 0;
        repeat (8) @(posedge clk_sys);
        `CHK({closed_window_time, open_window_time, heartbeat_period,
              answer_byte, rb_valid}, 24'h000000)
        `CHK(got.size(), 0)
        $display("test reset done");
        sel(0, `RBW_OFS_SEL_ENABLE, 8'hFF, `RBW_SEL_ENABLE_MASK);
        sel(1, `RBW_OFS_SEL_MAIN, 8'hFF, `RBW_SEL_MAIN_MASK);
        sel(2, `RBW_OFS_SEL_WD, 8'hFF, `RBW_SEL_WD_MASK);
        sel(1, `RBW_OFS_SEL_MAIN, 8'h41, `RBW_SEL_MAIN_MASK);
        sel(0, `RBW_OFS_SEL_ENABLE, 8'hE0, `RBW_SEL_ENABLE_MASK);
        sel(2, `RBW_OFS_SEL_WD, 8'h00, `RBW_SEL_WD_MASK);
        // second command stalls the bus while the first frame runs
        got.delete();
        apb(1, `RBW_APB_CMD, {16'h0000, `RBW_OFS_SEL_ENABLE, 8'h01});
        send(`RBW_OFS_SEL_WD, 8'h01);
        `CHK(got.size(), 2)
        `CHK({got[0], got[1]}, {5'd0, 5'd16})
        $display("test select done");
        send(`RBW_OFS_WINDOW, {6'h3F, 2'h3});
        `CHK({closed_window_time, open_window_time}, 8'hFF)
        send(`RBW_OFS_WINDOW, {6'h00, 2'h1});
        `CHK({closed_window_time, open_window_time}, 8'hFF)
        send(`RBW_OFS_WINDOW, {6'h01, 2'h2});
        `CHK({closed_window_time, open_window_time}, 8'h06)
        $display("test window done");
        a0 = n_ans;
        s0 = n_sync;
        send(`RBW_OFS_ANSWER, 8'hA5);
        `CHK({answer_byte, n_ans - a0, n_sync - s0}, {8'hA5, 32'd1, 32'd0})
        send(`RBW_OFS_ANSWER_SYNC, 8'h5A);
        `CHK({answer_byte, n_ans - a0, n_sync - s0}, {8'h5A, 32'd2, 32'd1})
        send(`RBW_OFS_HB_PERIOD, 8'h7F);
        `CHK({heartbeat_period, n_sync - s0}, {7'h7F, 32'd2})
        send(`RBW_OFS_HB_PERIOD, 8'h80);
        `CHK({heartbeat_period, n_sync - s0}, {7'h7F, 32'd3})
        // unmapped host address: refused, nothing reaches the link
        apb(1, 12'h008, {16'h0000, `RBW_OFS_ANSWER, 8'hFF});
        `CHK(er, 1'b1)
        apb(0, 12'h008, 0);
        `CHK({er, rd}, {1'b1, 32'h00000000})
        repeat (100) @(posedge clk_sys);
        `CHK({answer_byte, n_ans - a0}, {8'h5A, 32'd2})
        apb(0, `RBW_APB_CMD, 0);
        `CHK(rd, {16'h0000, `RBW_OFS_HB_PERIOD, 8'h80})
        $display("test watchdog done");
        // mid-run device reset clears every command field
        @(posedge lnk.lnk_clk);
        dev_rst <= 1;
        repeat (4) @(posedge lnk.lnk_clk);
        dev_rst <= 0;
        repeat (4) @(posedge lnk.lnk_clk);
        `CHK({closed_window_time, open_window_time, heartbeat_period,
              answer_byte, rb_valid}, 24'h000000)
        $display("test mid reset done");
        conclude();
    end
endmodule : readback_select_and_watchdog_cmds_test
